// file: logic/usart_clock_generation_map.svh
`ifndef USART_CLOCK_GENERATION_MAP_SVH
`define USART_CLOCK_GENERATION_MAP_SVH

// Byte offsets on the register bus.
`define OFF_DATA 5'h00
`define OFF_CTRL_STATUS_A 5'h04
`define OFF_CTRL_B 5'h08
`define OFF_CTRL_STATUS_C 5'h0C
`define OFF_BAUD_LOW 5'h10
`define OFF_BAUD_HIGH 5'h14

// Field positions of serial_ctrl_status_a.
`define A_RX_VALID 7
`define A_TX_EMPTY 5
`define A_FRAME_ERROR 4
`define A_OVERRUN 3
`define A_PARITY_ERROR 2
`define A_DOUBLE_SPEED 1
`define A_RX_NINTH 0

// Field positions of the control b register.
`define B_RX_EN 4
`define B_TX_EN 3
`define B_NINE_BIT 2
`define B_TX_NINTH 0

// Field positions of serial_ctrl_status_c.
`define C_XFER_DIR 7
`define C_SYNC_MODE 6
`define C_PARITY_HI 5
`define C_PARITY_LO 4
`define C_TWO_STOP 3
`define C_POLARITY 0

// Reset values, bit clock divisors and receive FIFO depth.
`define BAUD_RESET 12'h000
`define READDATA_RESET 8'h00
`define DIV_NORMAL 5'h10
`define DIV_DOUBLE 5'h08
`define DIV_SYNC 5'h02
`define FIFO_DEPTH 2'h2

`endif

// file: logic/usart_pkg.sv
package usart_pkg;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b01,
        RX_FRAME = 2'b10
    } rx_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic ninth;
        logic frame_err;
        logic pe;
        logic overrun;
    } rx_word_t;

    typedef struct packed {
        logic sync_mode_select;
        logic xfer_clock_direction;
        logic sync_clock_polarity;
        logic [1:0] parity_mode;
        logic two_stop;
        logic double_speed_bit;
        logic nine_bit;
        logic rx_en;
        logic tx_en;
        logic tx_ninth;
    } cfg_t;

    typedef struct packed {
        cfg_t cfg;
        logic [7:0] baud_divisor_low;
        logic [3:0] baud_divisor_high;
        logic [11:0] baud_cnt;
        logic waitrequest;
        logic [7:0] readdata;
        logic [3:0] tx_pre;
        logic [3:0] rx_phase;
        logic tclk_level;
        logic tclk_oe;
        logic [2:0] tclk_sync;
        logic [7:0] tx_buf;
        logic tx_buf_ninth;
        logic tx_buf_full;
        logic [12:0] tx_sh;
        logic [3:0] tx_left;
        logic txd;
        rx_state_t rx_state;
        logic [3:0] rx_idx;
        logic [9:0] rx_sh;
        rx_word_t held;
        logic held_valid;
        logic overrun_pending;
        rx_word_t [1:0] fifo;
        logic rd_ptr;
        logic wr_ptr;
        logic [1:0] count;
    } usart_state_t;

endpackage

// file: logic/usart_clock_generation.sv
// Design decisions made here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "usart_clock_generation_map.svh"

module usart_clock_generation
    import usart_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register bus
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Serial lines
    input wire logic rxd,
    output logic txd,
    // Transfer clock pin
    input wire logic tclk_in,
    output logic tclk_out,
    output logic tclk_oe,
    // Legacy compatibility strap
    input wire logic legacy_mode
);

    usart_state_t s;
    usart_state_t next_s;

    logic sync_on;
    logic master;
    logic baud_tick;
    logic [4:0] os;
    logic rise;
    logic fall;
    logic change_edge;
    logic sample_edge;
    logic tx_tick;
    logic rx_sample;
    logic start_seen;
    logic pop;
    logic [1:0] cnt;
    logic [16:0] frame;
    rx_word_t word;

    // Payload bits after the start bit: data, optional ninth, optional parity.
    function automatic logic [3:0] payload_len(input cfg_t c);
        payload_len = 4'h8 + {3'h0, c.nine_bit} + {3'h0, c.parity_mode[1]};
    endfunction

    // Frame is sent least significant bit first; the upper nibble is its length.
    function automatic logic [16:0] tx_frame(input logic [7:0] d, input logic ninth, input cfg_t c);
        logic [12:0] f;
        logic [3:0] p;
        logic par;
        f = 13'h1FFF;
        f[0] = 1'b0;
        f[8:1] = d;
        p = 4'h9;
        par = (^d) ^ (c.nine_bit & ninth) ^ c.parity_mode[0];
        if (c.nine_bit)
        begin
            f[p] = ninth;
            p = p + 4'h1;
        end
        if (c.parity_mode[1])
        begin
            f[p] = par;
            p = p + 4'h1;
        end
        p = p + 4'h1 + {3'h0, c.two_stop};
        tx_frame = {p, f};
    endfunction

    function automatic rx_word_t rx_decode(input logic [9:0] sh, input cfg_t c, input logic stop,
                                           input logic overrun);
        logic [9:0] a;
        logic [3:0] n;
        logic expect_par;
        n = payload_len(c);
        a = sh >> (4'hA - n);
        rx_decode.data = a[7:0];
        rx_decode.ninth = c.nine_bit & a[8];
        expect_par = (^a[7:0]) ^ (c.nine_bit & a[8]) ^ c.parity_mode[0];
        rx_decode.pe = c.parity_mode[1] & (a[n - 4'h1] != expect_par);
        rx_decode.frame_err = ~stop;
        rx_decode.overrun = overrun;
    endfunction

    always_comb
    begin
        next_s = s;
        // The legacy strap removes the synchronous modes altogether.
        sync_on = s.cfg.sync_mode_select & ~legacy_mode;
        master = sync_on & s.cfg.xfer_clock_direction;
        pop = 1'b0;
        word = '0;
        frame = '0;

        // Baud generator.
        baud_tick = (s.baud_cnt == 12'h000);
        if (baud_tick)
        begin
            next_s.baud_cnt = {s.baud_divisor_high, s.baud_divisor_low};
        end
        else
        begin
            next_s.baud_cnt = s.baud_cnt - 12'h001;
        end

        // Double speed is ignored in sync even if software leaves it set.
        if (sync_on)
        begin
            os = `DIV_SYNC;
        end
        else if (s.cfg.double_speed_bit)
        begin
            os = `DIV_DOUBLE;
        end
        else
        begin
            os = `DIV_NORMAL;
        end

        // Pin drive only in sync master; the pin is left alone otherwise.
        next_s.tclk_oe = master;
        if (!master)
        begin
            next_s.tclk_level = 1'b0;
        end
        else if (baud_tick)
        begin
            next_s.tclk_level = ~s.tclk_level;
        end

        // The first stage feeds only the second; slave edges come from the later stages, master edges from the baud tick.
        next_s.tclk_sync = {s.tclk_sync[1:0], tclk_in};
        if (master)
        begin
            rise = baud_tick & ~s.tclk_level;
            fall = baud_tick & s.tclk_level;
        end
        else
        begin
            rise = s.tclk_sync[1] & ~s.tclk_sync[2];
            fall = ~s.tclk_sync[1] & s.tclk_sync[2];
        end
        change_edge = s.cfg.sync_clock_polarity ? fall : rise;
        sample_edge = s.cfg.sync_clock_polarity ? rise : fall;

        // Transmit bit clock.
        if (baud_tick)
        begin
            next_s.tx_pre = ({1'b0, s.tx_pre} >= os - 5'h01) ? 4'h0 : s.tx_pre + 4'h1;
        end
        tx_tick = sync_on ? change_edge : (baud_tick && ({1'b0, s.tx_pre} == os - 5'h01));
        rx_sample = sync_on ? sample_edge : (baud_tick && ({1'b0, s.rx_phase} == (os >> 1)));
        start_seen = sync_on ? (sample_edge & ~rxd) : (baud_tick & ~rxd);

        // Transmitter: the buffer refills the shifter right after the last stop bit.
        if (!s.cfg.tx_en)
        begin
            next_s.txd = 1'b1;
            next_s.tx_left = 4'h0;
        end
        else if (tx_tick)
        begin
            if (s.tx_left != 4'h0)
            begin
                next_s.txd = s.tx_sh[0];
                next_s.tx_sh = {1'b1, s.tx_sh[12:1]};
                next_s.tx_left = s.tx_left - 4'h1;
            end
            else if (s.tx_buf_full)
            begin
                frame = tx_frame(s.tx_buf, s.tx_buf_ninth, s.cfg);
                next_s.txd = frame[0];
                next_s.tx_sh = {1'b1, frame[12:1]};
                next_s.tx_left = frame[16:13] - 4'h1;
                next_s.tx_buf_full = 1'b0;
            end
            else
            begin
                next_s.txd = 1'b1;
            end
        end

        // Register bus: one wait cycle, then the access commits.
        if (s.waitrequest)
        begin
            if (read || write)
            begin
                next_s.waitrequest = 1'b0;
                next_s.readdata = `READDATA_RESET;
                case (address)
                    `OFF_DATA:
                    begin
                        if (s.count != 2'h0)
                        begin
                            next_s.readdata = s.fifo[s.rd_ptr].data;
                        end
                    end
                    `OFF_CTRL_STATUS_A:
                    begin
                        next_s.readdata[`A_RX_VALID] = (s.count != 2'h0);
                        next_s.readdata[`A_TX_EMPTY] = ~s.tx_buf_full;
                        next_s.readdata[`A_FRAME_ERROR] = s.fifo[s.rd_ptr].frame_err;
                        next_s.readdata[`A_OVERRUN] = s.fifo[s.rd_ptr].overrun;
                        next_s.readdata[`A_PARITY_ERROR] = s.fifo[s.rd_ptr].pe;
                        next_s.readdata[`A_DOUBLE_SPEED] = s.cfg.double_speed_bit;
                        next_s.readdata[`A_RX_NINTH] = s.fifo[s.rd_ptr].ninth;
                    end
                    `OFF_CTRL_B:
                    begin
                        next_s.readdata[`B_RX_EN] = s.cfg.rx_en;
                        next_s.readdata[`B_TX_EN] = s.cfg.tx_en;
                        next_s.readdata[`B_NINE_BIT] = s.cfg.nine_bit;
                        next_s.readdata[`B_TX_NINTH] = s.cfg.tx_ninth;
                    end
                    `OFF_CTRL_STATUS_C:
                    begin
                        next_s.readdata[`C_XFER_DIR] = s.cfg.xfer_clock_direction;
                        next_s.readdata[`C_SYNC_MODE] = s.cfg.sync_mode_select;
                        next_s.readdata[`C_PARITY_HI:`C_PARITY_LO] = s.cfg.parity_mode;
                        next_s.readdata[`C_TWO_STOP] = s.cfg.two_stop;
                        next_s.readdata[`C_POLARITY] = s.cfg.sync_clock_polarity;
                    end
                    `OFF_BAUD_LOW: next_s.readdata = s.baud_divisor_low;
                    `OFF_BAUD_HIGH: next_s.readdata = {4'h0, s.baud_divisor_high};
                    default: next_s.readdata = `READDATA_RESET;
                endcase
            end
        end
        else
        begin
            next_s.waitrequest = 1'b1;
            // Reading the data word consumes it, flags included.
            pop = read && (address == `OFF_DATA) && (s.count != 2'h0);
            if (write && byteenable[0])
            begin
                case (address)
                    `OFF_DATA:
                    begin
                        // A write into a full buffer is dropped.
                        if (!s.tx_buf_full && s.cfg.tx_en)
                        begin
                            next_s.tx_buf = writedata[7:0];
                            next_s.tx_buf_ninth = s.cfg.tx_ninth;
                            next_s.tx_buf_full = 1'b1;
                        end
                    end
                    `OFF_CTRL_STATUS_A: next_s.cfg.double_speed_bit = writedata[`A_DOUBLE_SPEED];
                    `OFF_CTRL_B:
                    begin
                        next_s.cfg.rx_en = writedata[`B_RX_EN];
                        next_s.cfg.tx_en = writedata[`B_TX_EN];
                        next_s.cfg.nine_bit = writedata[`B_NINE_BIT];
                        next_s.cfg.tx_ninth = writedata[`B_TX_NINTH];
                    end
                    `OFF_CTRL_STATUS_C:
                    begin
                        next_s.cfg.xfer_clock_direction = writedata[`C_XFER_DIR];
                        next_s.cfg.sync_mode_select = writedata[`C_SYNC_MODE];
                        next_s.cfg.parity_mode = writedata[`C_PARITY_HI:`C_PARITY_LO];
                        next_s.cfg.two_stop = writedata[`C_TWO_STOP];
                        next_s.cfg.sync_clock_polarity = writedata[`C_POLARITY];
                    end
                    `OFF_BAUD_LOW:
                    begin
                        next_s.baud_divisor_low = writedata[7:0];
                        next_s.baud_cnt = {s.baud_divisor_high, writedata[7:0]};
                    end
                    // The high part waits for the next reload.
                    `OFF_BAUD_HIGH: next_s.baud_divisor_high = writedata[3:0];
                    default: next_s.readdata = s.readdata;
                endcase
            end
        end

        // Receive FIFO bookkeeping.
        cnt = s.count;
        if (pop)
        begin
            next_s.rd_ptr = ~s.rd_ptr;
            cnt = cnt - 2'h1;
        end
        if (s.held_valid && cnt != `FIFO_DEPTH)
        begin
            next_s.fifo[s.wr_ptr] = s.held;
            next_s.wr_ptr = ~s.wr_ptr;
            next_s.held_valid = 1'b0;
            cnt = cnt + 2'h1;
        end

        // Receiver.
        unique case (s.rx_state)
            RX_IDLE:
            begin
                next_s.rx_phase = 4'h1;
                if (s.cfg.rx_en && start_seen)
                begin
                    next_s.rx_state = RX_FRAME;
                    next_s.rx_idx = sync_on ? 4'h1 : 4'h0;
                    // A new start bit discards the word waiting in the held register.
                    if (next_s.held_valid)
                    begin
                        next_s.held_valid = 1'b0;
                        next_s.overrun_pending = 1'b1;
                    end
                end
            end
            RX_FRAME:
            begin
                if (!sync_on && baud_tick)
                begin
                    next_s.rx_phase = ({1'b0, s.rx_phase} >= os - 5'h01) ? 4'h0 : s.rx_phase + 4'h1;
                end
                if (rx_sample)
                begin
                    if (s.rx_idx == 4'h0)
                    begin
                        // A start bit that is high again at mid-bit was a glitch.
                        if (rxd)
                        begin
                            next_s.rx_state = RX_IDLE;
                        end
                        else
                        begin
                            next_s.rx_idx = 4'h1;
                        end
                    end
                    else if (s.rx_idx <= payload_len(s.cfg))
                    begin
                        next_s.rx_sh = {rxd, s.rx_sh[9:1]};
                        next_s.rx_idx = s.rx_idx + 4'h1;
                    end
                    else
                    begin
                        // Only the first stop bit is checked.
                        word = rx_decode(s.rx_sh, s.cfg, rxd, s.overrun_pending);
                        next_s.overrun_pending = 1'b0;
                        next_s.rx_state = RX_IDLE;
                        if (cnt != `FIFO_DEPTH)
                        begin
                            next_s.fifo[next_s.wr_ptr] = word;
                            next_s.wr_ptr = ~next_s.wr_ptr;
                            cnt = cnt + 2'h1;
                        end
                        else
                        begin
                            next_s.held = word;
                            next_s.held_valid = 1'b1;
                        end
                    end
                end
                if (!s.cfg.rx_en)
                begin
                    next_s.rx_state = RX_IDLE;
                end
            end
        endcase
        next_s.count = cnt;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s <= '0;
            s.baud_cnt <= `BAUD_RESET;
            s.txd <= 1'b1;
            s.waitrequest <= 1'b1;
            s.rx_state <= RX_IDLE;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign readdata = {24'h000000, s.readdata};
    assign waitrequest = s.waitrequest;
    assign txd = s.txd;
    assign tclk_out = s.tclk_level;
    assign tclk_oe = s.tclk_oe;

endmodule
`default_nettype wire

// file: verif/usart_clock_generation_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "usart_clock_generation_map.svh"
module usart_clock_generation_properties (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register bus
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Serial lines and transfer clock
    input wire logic txd,
    input wire logic tclk_out,
    input wire logic tclk_oe,
    input wire logic legacy_mode
);
    // The divisor is shadowed from committed writes, so rates are judged from the bus alone.
    logic [11:0] div;
    logic [19:0] tclk_run;
    logic [19:0] txd_run;
    logic [1:0] seen;
    logic tclk_prev;
    logic txd_prev;
    logic commit;
    logic tclk_edge;
    logic txd_edge;
    assign commit = write && !waitrequest && byteenable[0];
    assign tclk_edge = tclk_out != tclk_prev;
    assign txd_edge = txd != txd_prev;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    always_ff @(posedge clock)
    begin
        tclk_prev <= tclk_out;
        txd_prev <= txd;
        if (rst)
        begin
            div <= 12'h000;
            seen <= 2'h0;
            tclk_run <= 20'h00000;
            txd_run <= 20'h00000;
        end
        else
        begin
            if (commit && address == `OFF_BAUD_LOW)
                div[7:0] <= writedata[7:0];
            if (commit && address == `OFF_BAUD_HIGH)
                div[11:8] <= writedata[3:0];
            tclk_run <= tclk_edge ? 20'h00000 : tclk_run + 20'h00001;
            txd_run <= txd_edge ? 20'h00000 : (&txd_run ? txd_run : txd_run + 20'h00001);
            // A reload moves the phase, so two edges must pass before a whole level is timed.
            if (!tclk_oe || (commit && (address == `OFF_BAUD_LOW || address == `OFF_BAUD_HIGH)))
                seen <= 2'h0;
            else if (tclk_edge && seen != 2'h2)
                seen <= seen + 2'h1;
        end
    end
    AST_BUS_ANSWER: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered after one wait cycle");
    AST_BUS_ONE: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_BUS_IDLE: assert property (!read && !write && waitrequest |=> waitrequest)
        else $error("waitrequest dropped with no request");
    AST_READ_UPPER: assert property (read && !waitrequest |-> readdata[31:8] == 24'h000000)
        else $error("upper read data bits not zero");
    AST_UNMAPPED: assert property (read && !waitrequest && (address > `OFF_BAUD_HIGH || address[1:0] != 2'h0)
        |-> readdata == 32'h00000000) else $error("unmapped read not zero");
    AST_LEGACY_ASYNC: assert property (legacy_mode && $past(legacy_mode) && $past(legacy_mode, 2)
        |-> !tclk_oe && !tclk_out) else $error("transfer clock active in legacy configuration");
    AST_PIN_QUIET: assert property (!tclk_oe && !$past(tclk_oe) |-> !tclk_out)
        else $error("transfer clock output moves while not driven");
    AST_TCLK_RATE: assert property (tclk_oe && tclk_edge && seen == 2'h2 |-> tclk_run == {8'h00, div})
        else $error("master transfer clock level length wrong");
    AST_TXD_BIT: assert property (!tclk_oe && txd_edge |-> txd_run + 20'h00001 >= {div, 3'h0} + 20'h00008)
        else $error("asynchronous bit shorter than eight baud ticks");
endmodule
bind usart_clock_generation usart_clock_generation_properties u_usart_clock_generation_properties (
    .clock(clock), .rst(rst), .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .txd(txd),
    .tclk_out(tclk_out), .tclk_oe(tclk_oe), .legacy_mode(legacy_mode)
);
`default_nettype wire

// file: verif/remote_serial_partner.sv
`timescale 1ns/1ps
`default_nettype none
module remote_serial_partner (
    // Clock
    input wire logic clock,
    // Serial lines
    input wire logic txd,
    output logic rxd,
    output logic tclk_in,
    // Asynchronous bit time in system clocks
    input wire logic [15:0] bit_clocks
);
    logic [7:0] got[$];
    time starts[$];
    logic [7:0] b;
    time t;
    initial
    begin
        rxd = 1'b1;
        tclk_in = 1'b0;
    end
    // The start bit is checked again at mid-bit so that a glitch is not taken for a frame.
    initial
        forever
        begin
            @(negedge txd);
            t = $time;
            repeat (bit_clocks / 2) @(posedge clock);
            if (txd === 1'b0)
            begin
                for (int i = 0; i < 8; i++)
                begin
                    repeat (bit_clocks) @(posedge clock);
                    b[i] = txd;
                end
                got.push_back(b);
                starts.push_back(t);
            end
        end
    // A trailing idle bit lets back-to-back calls avoid two assignments in one time step.
    task automatic send_async(input logic [7:0] d, input logic stop);
        logic [10:0] f;
        f = {1'b1, stop, d, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            rxd <= f[i];
            repeat (bit_clocks) @(posedge clock);
        end
    endtask
    // The clock stands at its idle level outside frames; half is kept well above two system clocks.
    task automatic send_sync(input logic [7:0] d, input logic pol, input int half);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        tclk_in <= pol;
        repeat (half) @(posedge clock);
        for (int i = 0; i < 10; i++)
        begin
            tclk_in <= ~pol;
            rxd <= f[i];
            repeat (half) @(posedge clock);
            tclk_in <= pol;
            repeat (half) @(posedge clock);
        end
    endtask
endmodule
`default_nettype wire

// file: verif/usart_clock_generation_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "usart_clock_generation_map.svh"
module usart_clock_generation_bench;
    logic clock;
    logic rst;
    logic [4:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
    logic [31:0] readdata;
    logic waitrequest;
    logic rxd;
    logic txd;
    logic tclk_in;
    logic tclk_out;
    logic tclk_oe;
    logic legacy_mode;
    logic [15:0] bit_clocks;
    logic [31:0] rd;
    int n_fail = 0;
    int comparisons = 0;
    usart_clock_generation u_usart_clock_generation (
        .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .rxd(rxd), .txd(txd), .tclk_in(tclk_in), .tclk_out(tclk_out), .tclk_oe(tclk_oe), .legacy_mode(legacy_mode)
    );
    remote_serial_partner u_remote_serial_partner (
        .clock(clock), .txd(txd), .rxd(rxd), .tclk_in(tclk_in), .bit_clocks(bit_clocks)
    );
    initial
    begin
        clock = 1'b0;
        forever
            #4 clock = ~clock;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clock);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= {24'h000000, d};
        byteenable <= be;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 50);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        check({31'h0, waitrequest}, 32'h0);
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask
    task automatic rd_reg(input logic [4:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00, 4'h0);
        check(rd, {24'h000000, exp});
    endtask
    task automatic expect_word(input logic [7:0] d, input logic [7:0] flags);
        rd_reg(`OFF_CTRL_STATUS_A, 8'hA0 | flags);
        rd_reg(`OFF_DATA, d);
    endtask
    task automatic tclk_level(output int n);
        logic e;
        n = 0;
        e = tclk_out;
        while (tclk_out === e && n < 100)
        begin
            @(posedge clock);
            n++;
        end
    endtask
    task automatic t_regs;
        rd_reg(`OFF_CTRL_STATUS_C, 8'h00);
        rd_reg(`OFF_CTRL_STATUS_A, 8'h20);
        rd_reg(`OFF_BAUD_LOW, 8'h00);
        wr_reg(`OFF_BAUD_HIGH, 8'hFF);
        wr_reg(`OFF_BAUD_LOW, 8'hFF);
        bus(1'b1, `OFF_BAUD_LOW, 8'h12, 4'h0);
        rd_reg(`OFF_BAUD_HIGH, 8'h0F);
        rd_reg(`OFF_BAUD_LOW, 8'hFF);
        rd_reg(5'h18, 8'h00);
    endtask
    task automatic t_async_tx(input logic dbl);
        int n;
        n = 0;
        bit_clocks <= dbl ? 16'h0010 : 16'h0020;
        wr_reg(`OFF_BAUD_HIGH, 8'h00);
        wr_reg(`OFF_BAUD_LOW, 8'h01);
        wr_reg(`OFF_CTRL_STATUS_A, {6'h00, dbl, 1'b0});
        wr_reg(`OFF_CTRL_B, 8'h18);
        u_remote_serial_partner.got.delete();
        u_remote_serial_partner.starts.delete();
        wr_reg(`OFF_DATA, 8'hA5);
        do
            bus(1'b0, `OFF_CTRL_STATUS_A, 8'h00, 4'h0);
        while (rd[5] !== 1'b1 && n++ < 200);
        wr_reg(`OFF_DATA, 8'h3C);
        n = 0;
        while (u_remote_serial_partner.got.size() < 2 && n++ < 5000)
            @(posedge clock);
        check(32'(u_remote_serial_partner.got.size()), 32'h2);
        check({24'h0, u_remote_serial_partner.got[0]}, 32'hA5);
        check({24'h0, u_remote_serial_partner.got[1]}, 32'h3C);
        // Start to start spans exactly ten bits: no gap between buffered frames.
        check(32'(u_remote_serial_partner.starts[1] - u_remote_serial_partner.starts[0]), 32'(80 * bit_clocks));
    endtask
    task automatic t_rx_fifo;
        for (int i = 0; i < 3; i++)
            u_remote_serial_partner.send_async(8'h11 * 8'(i + 1), 1'b1);
        for (int i = 0; i < 3; i++)
            expect_word(8'h11 * 8'(i + 1), 8'h00);
        rd_reg(`OFF_CTRL_STATUS_A, 8'h20);
        rd_reg(`OFF_DATA, 8'h00);
        for (int i = 0; i < 4; i++)
            u_remote_serial_partner.send_async(8'h44 + 8'h11 * 8'(i), 1'b1);
        expect_word(8'h44, 8'h00);
        expect_word(8'h55, 8'h00);
        expect_word(8'h77, 8'h08);
        u_remote_serial_partner.send_async(8'h5A, 1'b0);
        expect_word(8'h5A, 8'h10);
    endtask
    task automatic t_sync;
        int n;
        wr_reg(`OFF_BAUD_LOW, 8'h02);
        wr_reg(`OFF_CTRL_STATUS_C, 8'hC0);
        repeat (4) @(posedge clock);
        check({31'h0, tclk_oe}, 32'h1);
        tclk_level(n);
        tclk_level(n);
        check(32'(n), 32'h3);
        legacy_mode <= 1'b1;
        repeat (3) @(posedge clock);
        check({31'h0, tclk_oe}, 32'h0);
        legacy_mode <= 1'b0;
        wr_reg(`OFF_CTRL_STATUS_C, 8'h00);
        repeat (3) @(posedge clock);
        check({30'h0, tclk_oe, tclk_out}, 32'h0);
        // A slow internal divisor shows that slave timing does not lean on the baud counter.
        wr_reg(`OFF_BAUD_HIGH, 8'h0F);
        wr_reg(`OFF_BAUD_LOW, 8'hFF);
        wr_reg(`OFF_CTRL_STATUS_C, 8'h40);
        u_remote_serial_partner.send_sync(8'h96, 1'b0, 8);
        check({31'h0, tclk_oe}, 32'h0);
        expect_word(8'h96, 8'h00);
        wr_reg(`OFF_CTRL_STATUS_C, 8'h41);
        u_remote_serial_partner.send_sync(8'h69, 1'b1, 8);
        expect_word(8'h69, 8'h00);
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        rst = 1'b1;
        address = 5'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h00000000;
        byteenable = 4'h0;
        legacy_mode = 1'b0;
        bit_clocks = 16'h0020;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        check({28'h0, waitrequest, txd, tclk_oe, tclk_out}, 32'hC);
        t_regs();
        t_async_tx(1'b1);
        t_async_tx(1'b0);
        t_rx_fifo();
        t_sync();
        results();
    end
    // About ten times the expected length of the run.
    initial
    begin
        #400000;
        n_fail++;
        results();
    end
endmodule
`default_nettype wire
